// ==== core/vreg_i2c_pkg.sv ====
/*
 Constants shared by the virtual register I2C slave: slave address,
 physical register offsets, status bit positions, virtual address fields
 and integration timing. Assumes a 100 MHz core clock.
*/
package vreg_i2c_pkg;
	// Bus address and physical byte registers.
	localparam logic [6:0] SLAVE_ADDR     = 7'h49;
	localparam logic [7:0] STATUS_OFS     = 8'h00;
	localparam logic [7:0] WRITE_OFS      = 8'h01;
	localparam logic [7:0] READ_OFS       = 8'h02;
	localparam int         RX_VALID_BIT   = 0;
	localparam int         TX_VALID_BIT   = 1;
	localparam logic [7:0] STATUS_RESET   = 8'h00;
	localparam logic [7:0] HOLD_RESET     = 8'h00;

	// Virtual address byte layout and decoded addresses.
	localparam int         VWRITE_BIT     = 7;
	localparam logic [6:0] CTRL_VADDR     = 7'h0c;
	localparam logic [6:0] SENSOR_FIRST   = 7'h18;
	localparam logic [6:0] SENSOR_LAST    = 7'h3e;

	// Bank modes.
	localparam logic [1:0] BANK_BOTH      = 2'h2;

	// Integration time unit and its length in core cycles.
	localparam int         CLK_MHZ        = 100;
	localparam int         INTEG_UNIT_US  = 2800;
	localparam int         INTEG_UNIT_CYC = INTEG_UNIT_US * CLK_MHZ;
	localparam int         UNIT_W         = 24;

	typedef enum logic [3:0] {
		L_IDLE      = 4'b0000,
		L_ADDR      = 4'b0001,
		L_ACK_ADDR  = 4'b0010,
		L_PTR       = 4'b0011,
		L_ACK_PTR   = 4'b0100,
		L_WDATA     = 4'b0101,
		L_ACK_WDATA = 4'b0110,
		L_RDATA     = 4'b0111,
		L_ACK_RD    = 4'b1000
	} link_state_t;
endpackage

// ==== core/vreg_i2c_slave.sv ====
/*
 Host facing I2C slave with three physical byte registers, the virtual
 register byte protocol toward the internal controller, and the data
 ready and interrupt logic of the integration timer.
 Assumes SCL and SDA are resolved by the bench from SDA_OE, LINK_CLK is
 a free running sampling clock at least ten times the SCL rate, and the
 controller inputs are synchronous to CLK.
*/
// Notes on behaviour
// RULE1: Modes 0 and 1 ready each period.
// RULE2: Mode 2 ready every second period.
// RULE3: Ready sets flag, interrupt low if enabled.
// RULE4: Reading control register releases interrupt.
// RULE5: Reading sensor registers clears ready flag.
// RULE6: Hold remaining bytes after first read.
// RULE7: Conversion runs on whether read or not.
// RULE8: Text mode: any sensor read releases interrupt.
// RULE9: Select pin enables the I2C slave port.
// RULE10: Three byte registers at 0, 1, 2.
// RULE11: Standard and fast speed, single bytes.
// RULE12: Answer bus address 49 hex only.
// RULE13: Status bit 1 shows write holding busy.
// RULE14: Status bit 0 shows read byte waiting.
// RULE15: Write holding carries addresses and data.
// RULE16: Address top bit selects write or read.
// RULE17: Host waits before address and data.
// RULE18: Consumed write address frees holding register.
// RULE19: Host writes read address unmodified.
// RULE20: Read byte arriving sets status bit 0.
// RULE21: Host walks multi-byte values upward.
// RULE22: Busy from host write until consumed.
`timescale 1ns/1ns
module vreg_i2c_slave
	import vreg_i2c_pkg::*;
#(
	parameter int UNIT_CYCLES = INTEG_UNIT_CYC
) (
	// Core clock and reset.
	input  wire logic       CLK,
	input  wire logic       ARST_N,
	// Link sampling clock and I2C pins.
	input  wire logic       LINK_CLK,
	input  wire logic       SCL_I,
	input  wire logic       SDA_I,
	output logic            SDA_O,
	output logic            SDA_OE,
	input  wire logic       SERIAL_PORT_SELECT,
	// Virtual register access toward the controller.
	output logic            VWR_STROBE,
	output logic [6:0]      VWR_ADDR,
	output logic [7:0]      VWR_DATA,
	output logic            VRD_REQ,
	output logic [6:0]      VRD_ADDR,
	input  wire logic       VRD_ACK,
	input  wire logic [7:0] VRD_DATA,
	// Conversion setup and text command reads.
	input  wire logic [1:0] BANK_MODE,
	input  wire logic       INT_ENABLE,
	input  wire logic [7:0] INTEG_TIME,
	input  wire logic       TEXT_SENSOR_READ,
	// Conversion status.
	output logic            INT_N,
	output logic            DATA_RDY,
	output logic            DATA_UPDATE,
	output logic            SHADOW_HOLD
);

	// Link domain state.
	link_state_t state;
	logic [2:0]  scl_s;
	logic [2:0]  sda_s;
	logic [1:0]  sel_l;
	logic [3:0]  bitcnt;
	logic [7:0]  shreg;
	logic [7:0]  ptr;
	logic        rw;
	logic        nack;
	logic        sda_oe;
	logic [7:0]  wh_data;
	logic        wh_full;
	logic        wr_tgl;
	logic [2:0]  ack_s;
	logic [2:0]  rd_s;
	logic [7:0]  rd_holding;
	logic        rx_valid;
	logic [7:0]  rd_byte;

	// Core domain state.
	logic [2:0]  wr_s;
	logic [1:0]  sel_c;
	logic        ack_tgl;
	logic        rd_tgl;
	logic [7:0]  rd_data;
	logic        pend_write;
	logic [6:0]  vaddr;
	logic [UNIT_W-1:0] unit_cnt;
	logic [7:0]  period_cnt;
	logic        phase;
	logic        int_pend;

	logic scl, sda, scl_rise, scl_fall, start, stop;
	logic wh_store, ack_evt, rd_evt, load, byte_end;
	assign scl      = scl_s[1];
	assign sda      = sda_s[1];
	assign scl_rise = scl_s[1] & ~scl_s[2];
	assign scl_fall = ~scl_s[1] & scl_s[2];
	assign start    = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
	assign stop     = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];
	assign byte_end = scl_fall && bitcnt == 4'h8;
	assign ack_evt  = ack_s[2] ^ ack_s[1];
	assign rd_evt   = rd_s[2] ^ rd_s[1];
	assign load     = scl_fall && ((state == L_ACK_ADDR && rw) || (state == L_ACK_RD && !nack));
	assign SDA_O    = 1'b0;
	assign SDA_OE   = sda_oe;

	// The first stage of each chain feeds only the second stage.
	always_ff @(posedge LINK_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			scl_s <= 3'h7;
			sda_s <= 3'h7;
			sel_l <= 2'h0;
			ack_s <= 3'h0;
			rd_s  <= 3'h0;
		end else begin
			scl_s <= {scl_s[1:0], SCL_I};
			sda_s <= {sda_s[1:0], SDA_I};
			sel_l <= {sel_l[0], SERIAL_PORT_SELECT};
			ack_s <= {ack_s[1:0], ack_tgl};
			rd_s  <= {rd_s[1:0], rd_tgl};
		end
	end

	// RULE10: physical register read mux.
	always_comb begin
		case (ptr)
			STATUS_OFS: begin
				rd_byte = STATUS_RESET;
				// RULE13: write busy bit.
				rd_byte[TX_VALID_BIT] = wh_full;
				// RULE14: read waiting bit.
				rd_byte[RX_VALID_BIT] = rx_valid;
			end
			READ_OFS: rd_byte = rd_holding;
			default:  rd_byte = 8'h00;
		endcase
	end

	// RULE11: byte transfer state machine on sampled pins.
	always_ff @(posedge LINK_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state  <= L_IDLE;
			bitcnt <= 4'h0;
			shreg  <= 8'h00;
			ptr    <= STATUS_OFS;
			rw     <= 1'b0;
			nack   <= 1'b0;
			sda_oe <= 1'b0;
		end else if (start) begin
			state  <= L_ADDR;
			bitcnt <= 4'h0;
			sda_oe <= 1'b0;
		end else if (stop) begin
			state  <= L_IDLE;
			sda_oe <= 1'b0;
		end else begin
			case (state)
				L_ADDR, L_PTR, L_WDATA: begin
					if (scl_rise) begin
						shreg  <= {shreg[6:0], sda};
						bitcnt <= bitcnt + 4'h1;
					end else if (byte_end) begin
						bitcnt <= 4'h0;
						if (state == L_ADDR) begin
							// RULE12: match address, latch direction.
							// RULE9: silent unless the port is selected.
							if (shreg[7:1] == SLAVE_ADDR && sel_l[1]) begin
								sda_oe <= 1'b1;
								rw     <= shreg[0];
								state  <= L_ACK_ADDR;
							end else begin
								state <= L_IDLE;
							end
						end else begin
							sda_oe <= 1'b1;
							if (state == L_PTR) begin
								ptr   <= shreg;
								state <= L_ACK_PTR;
							end else begin
								state <= L_ACK_WDATA;
							end
						end
					end
				end
				L_ACK_ADDR: begin
					if (scl_fall) begin
						if (rw) begin
							shreg  <= rd_byte;
							sda_oe <= ~rd_byte[7];
							state  <= L_RDATA;
						end else begin
							sda_oe <= 1'b0;
							state  <= L_PTR;
						end
					end
				end
				L_ACK_PTR, L_ACK_WDATA: begin
					if (scl_fall) begin
						sda_oe <= 1'b0;
						state  <= L_WDATA;
					end
				end
				L_RDATA: begin
					if (scl_rise) begin
						bitcnt <= bitcnt + 4'h1;
					end else if (byte_end) begin
						bitcnt <= 4'h0;
						sda_oe <= 1'b0;
						state  <= L_ACK_RD;
					end else if (scl_fall) begin
						shreg  <= {shreg[6:0], 1'b0};
						sda_oe <= ~shreg[6];
					end
				end
				L_ACK_RD: begin
					if (scl_rise) begin
						nack <= sda;
					end else if (scl_fall) begin
						if (nack) begin
							state <= L_IDLE;
						end else begin
							shreg  <= rd_byte;
							sda_oe <= ~rd_byte[7];
							state  <= L_RDATA;
						end
					end
				end
				default: state <= L_IDLE;
			endcase
		end
	end

	// A byte written while the holding register is busy is acked but dropped.
	assign wh_store = state == L_WDATA && byte_end && ptr == WRITE_OFS && !wh_full;

	// RULE22: busy from host write until the core returns its toggle.
	always_ff @(posedge LINK_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			wh_full <= 1'b0;
			wh_data <= HOLD_RESET;
			wr_tgl  <= 1'b0;
		end else if (wh_store) begin
			wh_full <= 1'b1;
			wh_data <= shreg;
			wr_tgl  <= ~wr_tgl;
		end else if (ack_evt) begin
			wh_full <= 1'b0;
		end
	end

	// RULE20: byte from the controller sets status bit 0, set beats clear.
	always_ff @(posedge LINK_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rx_valid   <= 1'b0;
			rd_holding <= HOLD_RESET;
		end else if (rd_evt) begin
			rx_valid   <= 1'b1;
			rd_holding <= rd_data;
		end else if (load && ptr == READ_OFS) begin
			rx_valid <= 1'b0;
		end
	end

	wh_busy_a: assert property (@(posedge LINK_CLK) disable iff (!ARST_N) // RULE22
		wh_store |=> wh_full [*2]) else $error("write holding not busy after store");
	rx_set_a: assert property (@(posedge LINK_CLK) disable iff (!ARST_N) // RULE20
		rd_evt |=> rx_valid && rd_holding == $past(rd_data)) else $error("read byte not posted");
	addr_ack_a: assert property (@(posedge LINK_CLK) disable iff (!ARST_N) // RULE12
		state == L_ADDR && byte_end && shreg[7:1] != SLAVE_ADDR |=> !sda_oe)
		else $error("acked a foreign address");

	// Core side: byte handshake from the link and virtual protocol.
	logic       wr_evt;
	logic [7:0] wr_byte;
	logic       i2c_mode;
	logic       rd_sensor;
	logic       rd_ctrl;
	assign wr_evt    = wr_s[2] ^ wr_s[1];
	assign wr_byte   = wh_data;
	assign i2c_mode  = sel_c[1];
	assign rd_sensor = VRD_REQ && VRD_ADDR >= SENSOR_FIRST && VRD_ADDR <= SENSOR_LAST;
	assign rd_ctrl   = VRD_REQ && VRD_ADDR == CTRL_VADDR;

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			wr_s  <= 3'h0;
			sel_c <= 2'h0;
		end else begin
			wr_s  <= {wr_s[1:0], wr_tgl};
			sel_c <= {sel_c[0], SERIAL_PORT_SELECT};
		end
	end

	// RULE15: each held byte is taken in turn; wh_data is stable while busy.
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			pend_write <= 1'b0;
			vaddr      <= 7'h00;
			ack_tgl    <= 1'b0;
			VWR_STROBE <= 1'b0;
			VWR_ADDR   <= 7'h00;
			VWR_DATA   <= 8'h00;
			VRD_REQ    <= 1'b0;
			VRD_ADDR   <= 7'h00;
		end else begin
			VWR_STROBE <= 1'b0;
			VRD_REQ    <= 1'b0;
			if (wr_evt) begin
				// RULE18: release the holding register once consumed.
				ack_tgl <= ~ack_tgl;
				if (pend_write) begin
					pend_write <= 1'b0;
					VWR_STROBE <= 1'b1;
					VWR_ADDR   <= vaddr;
					VWR_DATA   <= wr_byte;
				// RULE16: top bit 1 announces a write.
				end else if (wr_byte[VWRITE_BIT]) begin
					pend_write <= 1'b1;
					vaddr      <= wr_byte[6:0];
				end else begin
					VRD_REQ  <= 1'b1;
					VRD_ADDR <= wr_byte[6:0];
				end
			end
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rd_tgl  <= 1'b0;
			rd_data <= HOLD_RESET;
		end else if (VRD_ACK) begin
			rd_tgl  <= ~rd_tgl;
			rd_data <= VRD_DATA;
		end
	end

	// RULE7: the integration timer runs free of any host activity.
	logic unit_end, period_end, ready_evt;
	logic [7:0] integ_eff;
	assign integ_eff  = (INTEG_TIME == 8'h00) ? 8'h01 : INTEG_TIME;
	assign unit_end   = unit_cnt == UNIT_W'(UNIT_CYCLES - 1);
	// A shorter integration time ends the running period at the end of the current unit instead of wrapping the count.
	assign period_end = unit_end && period_cnt >= integ_eff - 8'h01;
	// RULE1: single bank modes. RULE2: both banks need two periods.
	assign ready_evt  = period_end && (BANK_MODE != BANK_BOTH || phase);

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			unit_cnt   <= '0;
			period_cnt <= 8'h00;
			phase      <= 1'b0;
		end else begin
			unit_cnt <= unit_end ? '0 : unit_cnt + UNIT_W'(1);
			if (period_end) begin
				period_cnt <= 8'h00;
				phase      <= (BANK_MODE == BANK_BOTH) ? ~phase : 1'b0;
			end else if (unit_end) begin
				period_cnt <= period_cnt + 8'h01;
			end
		end
	end

	// RULE3: new data raises the flag and, if enabled, the interrupt.
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			int_pend    <= 1'b0;
			DATA_RDY    <= 1'b0;
			DATA_UPDATE <= 1'b0;
		end else begin
			DATA_UPDATE <= ready_evt;
			if (ready_evt && INT_ENABLE) begin
				int_pend <= 1'b1;
			// RULE4: control read releases. RULE8: text mode sensor read.
			end else if (i2c_mode ? rd_ctrl : TEXT_SENSOR_READ) begin
				int_pend <= 1'b0;
			end
			if (ready_evt) begin
				DATA_RDY <= 1'b1;
			// RULE5: any sensor read clears the flag.
			end else if (i2c_mode ? rd_sensor : TEXT_SENSOR_READ) begin
				DATA_RDY <= 1'b0;
			end
		end
	end
	assign INT_N = ~int_pend;

	// RULE6: an even sensor address starts a held pair until the next read.
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			SHADOW_HOLD <= 1'b0;
		end else if (VRD_REQ) begin
			SHADOW_HOLD <= rd_sensor && !VRD_ADDR[0];
		end
	end

	mode01_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE1
		period_end && BANK_MODE != BANK_BOTH |=> DATA_RDY && DATA_UPDATE)
		else $error("single bank period gave no data");
	mode2_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE2
		period_end && BANK_MODE == BANK_BOTH && !phase |-> !ready_evt)
		else $error("both banks ready after one period");
	int_low_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE3
		ready_evt && INT_ENABLE |=> !INT_N && DATA_RDY) else $error("interrupt not raised");
	int_off_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE3
		!INT_ENABLE && INT_N |=> INT_N) else $error("interrupt while disabled");
	int_release_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE4
		i2c_mode && rd_ctrl && !ready_evt |=> INT_N) else $error("control read kept interrupt");
	rdy_clear_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE5
		i2c_mode && rd_sensor && !ready_evt |=> !DATA_RDY) else $error("ready flag not cleared");
	text_release_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE8
		!i2c_mode && TEXT_SENSOR_READ && !ready_evt |=> INT_N) else $error("text read kept int");
	hold_pair_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE6
		rd_sensor && !VRD_ADDR[0] |=> SHADOW_HOLD) else $error("first byte not held");
	vwrite_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE16
		wr_evt && !pend_write && wr_byte[VWRITE_BIT] |=> pend_write && !VRD_REQ && !VWR_STROBE)
		else $error("write address mishandled");
	vread_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE16
		wr_evt && !pend_write && !wr_byte[VWRITE_BIT] |=> VRD_REQ && VRD_ADDR == $past(wr_byte[6:0]))
		else $error("read request missing");
	vdata_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE15
		wr_evt && pend_write |=> VWR_STROBE && VWR_ADDR == $past(vaddr) && !pend_write)
		else $error("write data not delivered");
	consume_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE18
		wr_evt |=> ack_tgl != $past(ack_tgl)) else $error("byte not released");

endmodule

// ==== sim/i2c_host_model.sv ====
/*
 Behavioural I2C host for the virtual register slave: byte transfers and
 the polled virtual write and read sequences.
 Assumes an external pull-up resolves SDA and that SCL idles high.
*/
`timescale 1ns/1ns
module i2c_host_model
	import vreg_i2c_pkg::*;
(
	// Bus lines driven and seen by the host.
	output logic      scl,
	output logic      sda_pull,
	input  wire logic sda
);
	// A quarter of the SCL period; 160 ns keeps the run short, 625 ns gives the fast rate.
	int q = 160;

	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	// Data changes a quarter period after SCL falls, so it never looks like a frame edge.
	task automatic put_bit(input logic b);
		sda_pull = !b;
		#q scl = 1'b1;
		#(2*q) scl = 1'b0;
		#q;
	endtask

	task automatic get_bit(output logic b);
		sda_pull = 1'b0;
		#q scl = 1'b1;
		#q b = sda;
		#q scl = 1'b0;
		#q;
	endtask

	task automatic start_frame;
		sda_pull = 1'b1;
		#q scl = 1'b0;
		#q;
	endtask

	task automatic stop_frame;
		sda_pull = 1'b1;
		#q scl = 1'b1;
		#q sda_pull = 1'b0;
		#q;
	endtask

	task automatic byte_out(input logic [7:0] v, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) put_bit(v[i]);
		get_bit(a);
		ack = !a;
	endtask

	task automatic byte_in(output logic [7:0] v);
		for (int i = 7; i >= 0; i--) get_bit(v[i]);
		put_bit(1'b1);
	endtask

	task automatic probe(input logic [6:0] a7, output logic ack);
		start_frame;
		byte_out({a7, 1'b0}, ack);
		stop_frame;
	endtask

	task automatic reg_wr(input logic [7:0] ptr, input logic [7:0] d);
		logic a;
		start_frame;
		byte_out({SLAVE_ADDR, 1'b0}, a);
		byte_out(ptr, a);
		byte_out(d, a);
		stop_frame;
	endtask

	task automatic reg_rd(input logic [7:0] ptr, output logic [7:0] d);
		logic a;
		start_frame;
		byte_out({SLAVE_ADDR, 1'b0}, a);
		byte_out(ptr, a);
		stop_frame;
		start_frame;
		byte_out({SLAVE_ADDR, 1'b1}, a);
		byte_in(d);
		stop_frame;
	endtask

	task automatic wait_free;
		logic [7:0] st;
		for (int i = 0; i < 20; i++) begin
			reg_rd(STATUS_OFS, st);
			if (st[TX_VALID_BIT] === 1'b0) break;
		end
	endtask

	task automatic vwrite(input logic [6:0] a, input logic [7:0] d);
		wait_free;
		reg_wr(WRITE_OFS, {1'b1, a});
		wait_free;
		reg_wr(WRITE_OFS, d);
	endtask

	task automatic vread(input logic [6:0] a, output logic [7:0] d);
		logic [7:0] st;
		wait_free;
		reg_wr(WRITE_OFS, {1'b0, a});
		for (int i = 0; i < 20; i++) begin
			reg_rd(STATUS_OFS, st);
			if (st[RX_VALID_BIT] === 1'b1) break;
		end
		reg_rd(READ_OFS, d);
	endtask
endmodule

// ==== sim/virtual_register_i2c_slave_test.sv ====
/*
 Self-checking bench for the virtual register I2C slave, with a controller
 model on the virtual side and a flag model for ready and interrupt.
 Assumes the host model is compiled first; the unit count is shortened.
*/
`timescale 1ns/1ns
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module virtual_register_i2c_slave_test
	import vreg_i2c_pkg::*;
;
	logic       CLK, ARST_N, LINK_CLK, SERIAL_PORT_SELECT, VRD_ACK, INT_ENABLE;
	logic       TEXT_SENSOR_READ, ack;
	logic [7:0] VRD_DATA, INTEG_TIME, st, d, ctrl_data, wr_data;
	logic [1:0] BANK_MODE;
	logic [6:0] rd_addr, wr_addr;
	wire        scl, sda_pull, sda_oe, sda, VWR_STROBE, VRD_REQ;
	wire        INT_N, DATA_RDY, DATA_UPDATE, SHADOW_HOLD;
	wire  [6:0] VWR_ADDR, VRD_ADDR;
	wire  [7:0] VWR_DATA;
	logic       exp_rdy = 1'b0, exp_int_n = 1'b1, ie_q = 1'b0;
	int         mismatches = 0, checks_done = 0, wr_cnt = 0, rd_cnt = 0, n;
	logic [6:0] va [3] = '{SENSOR_FIRST, SENSOR_FIRST + 7'h01, CTRL_VADDR};

	assign sda = !(sda_oe | sda_pull);

	vreg_i2c_slave #(.UNIT_CYCLES(20)) dut (.CLK(CLK), .ARST_N(ARST_N),
		.LINK_CLK(LINK_CLK), .SCL_I(scl), .SDA_I(sda), .SDA_O(), .SDA_OE(sda_oe),
		.SERIAL_PORT_SELECT(SERIAL_PORT_SELECT), .VWR_STROBE(VWR_STROBE),
		.VWR_ADDR(VWR_ADDR), .VWR_DATA(VWR_DATA), .VRD_REQ(VRD_REQ),
		.VRD_ADDR(VRD_ADDR), .VRD_ACK(VRD_ACK), .VRD_DATA(VRD_DATA),
		.BANK_MODE(BANK_MODE), .INT_ENABLE(INT_ENABLE), .INTEG_TIME(INTEG_TIME),
		.TEXT_SENSOR_READ(TEXT_SENSOR_READ), .INT_N(INT_N), .DATA_RDY(DATA_RDY),
		.DATA_UPDATE(DATA_UPDATE), .SHADOW_HOLD(SHADOW_HOLD));
	i2c_host_model host (.scl(scl), .sda_pull(sda_pull), .sda(sda));

	initial begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end
	initial begin
		LINK_CLK = 1'b0;
		#7;
		forever #24 LINK_CLK = ~LINK_CLK;
	end

	task conclude;
		if (mismatches == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task tick;
		@(posedge CLK);
		#1;
	endtask

	task wait_upd(output int c);
		c = 0;
		do begin
			@(negedge CLK);
			c++;
		end while (DATA_UPDATE !== 1'b1 && c < 2000);
	endtask

	task measure(input logic [1:0] m, input logic [7:0] it);
		int exp_p;
		exp_p = 20 * (it == 0 ? 1 : it) * (m == BANK_BOTH ? 2 : 1);
		tick;
		BANK_MODE = m;
		INTEG_TIME = it;
		repeat (3) wait_upd(n);
		wait_upd(n);
		`CHK(n, exp_p)
	endtask

	// The controller answers after a random wait, then scrambles its data lines.
	always begin
		@(posedge CLK);
		if (VRD_REQ === 1'b1) begin
			rd_cnt++;
			rd_addr = VRD_ADDR;
			repeat ($urandom_range(1, 6)) @(posedge CLK);
			#1 ctrl_data = 8'($urandom);
			VRD_ACK = 1'b1;
			VRD_DATA = ctrl_data;
			tick;
			VRD_ACK = 1'b0;
			VRD_DATA = ~ctrl_data;
		end
	end

	always @(posedge CLK) begin
		if (VWR_STROBE === 1'b1) begin
			wr_cnt++;
			wr_addr = VWR_ADDR;
			wr_data = VWR_DATA;
		end
		if (ARST_N && VRD_REQ && VRD_ADDR >= SENSOR_FIRST && VRD_ADDR <= SENSOR_LAST)
			exp_rdy = 1'b0;
		if (ARST_N && VRD_REQ && VRD_ADDR == CTRL_VADDR)
			exp_int_n = 1'b1;
		if (ARST_N && TEXT_SENSOR_READ) begin
			exp_rdy = 1'b0;
			exp_int_n = 1'b1;
		end
		ie_q = INT_ENABLE;
	end

	// Set wins over clear, since the clear was already applied at the edge.
	always @(negedge CLK) begin
		if (ARST_N) begin
			if (DATA_UPDATE === 1'b1) begin
				exp_rdy = 1'b1;
				if (ie_q) exp_int_n = 1'b0;
			end
			`CHK(DATA_RDY, exp_rdy)
			`CHK(INT_N, exp_int_n)
		end
	end

	initial begin
		#1000000;
		mismatches++;
		conclude;
	end

	initial begin
		void'($urandom(41));
		ARST_N = 1'b0;
		SERIAL_PORT_SELECT = 1'b1;
		VRD_ACK = 1'b0;
		VRD_DATA = 8'h00;
		INT_ENABLE = 1'b0;
		TEXT_SENSOR_READ = 1'b0;
		BANK_MODE = 2'h0;
		INTEG_TIME = 8'h01;
		repeat (10) @(posedge CLK);
		#1 ARST_N = 1'b1;
		for (int m = 0; m < 4; m++) measure(m[1:0], 8'($urandom_range(0, 3)));
		tick;
		BANK_MODE = 2'h0;
		INTEG_TIME = 8'hff;
		INT_ENABLE = 1'b1;
		host.reg_rd(STATUS_OFS, st);
		`CHK(st, STATUS_RESET)
		d = 8'($urandom);
		host.vwrite(7'h0f, d);
		`CHK({wr_addr, wr_data}, {7'h0f, d})
		`CHK(wr_cnt + rd_cnt, 1)
		host.reg_rd(STATUS_OFS, st);
		`CHK(st[TX_VALID_BIT], 1'b0)
		for (int a = 0; a < 3; a++) begin
			host.vread(va[a], d);
			`CHK({rd_addr, d}, {va[a], ctrl_data})
			`CHK(SHADOW_HOLD, a == 0)
			host.reg_rd(STATUS_OFS, st);
			`CHK(st, 8'h00)
		end
		host.reg_rd(8'h03, st);
		`CHK(st, 8'h00)
		host.q = 625;
		host.probe(SLAVE_ADDR ^ 7'h01, ack);
		`CHK(ack, 1'b0)
		host.q = 2500;
		host.probe(SLAVE_ADDR, ack);
		`CHK(ack, 1'b1)
		host.q = 625;
		tick;
		SERIAL_PORT_SELECT = 1'b0;
		INTEG_TIME = 8'h01;
		repeat (50) tick;
		host.probe(SLAVE_ADDR, ack);
		`CHK(ack, 1'b0)
		wait_upd(n);
		tick;
		TEXT_SENSOR_READ = 1'b1;
		tick;
		TEXT_SENSOR_READ = 1'b0;
		tick;
		`CHK(INT_N, 1'b1)
		conclude;
	end
endmodule
